//--- serial_port_irq_mask_pkg.sv
package serial_port_irq_mask_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Byte addresses of the register port
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_ENABLE_SET = 8'h04;
    localparam logic [7:0] OFS_ENABLE_CLEAR = 8'h08;
    localparam logic [7:0] OFS_MASK_VIEW = 8'h0C;

    // Source bit positions, shared by status, set, clear and mask, except bits 16 and 17, which exist in status only
    localparam int BIT_TX_HOLDING_FREE = 0;
    localparam int BIT_TX_ALL_SENT = 1;
    localparam int BIT_TX_DMA_COUNT_DONE = 2;
    localparam int BIT_TX_DMA_BUFFERS_EMPTY = 3;
    localparam int BIT_RX_HOLDING_FULL = 4;
    localparam int BIT_RX_OVERRUN_FLAG = 5;
    localparam int BIT_RX_DMA_COUNT_DONE = 6;
    localparam int BIT_RX_DMA_BUFFERS_FULL = 7;
    localparam int BIT_TX_FRAME_SYNC_SEEN = 10;
    localparam int BIT_RX_FRAME_SYNC_SEEN = 11;
    localparam int BIT_TX_ENABLED = 16;
    localparam int BIT_RX_ENABLED = 17;

    // Bits that exist in set, clear and mask
    localparam logic [31:0] SOURCE_MASK = 32'h00000CFF;

    // Sticky flag slots
    localparam int STICKY_W = 3;
    localparam int STK_OVERRUN = 0;
    localparam int STK_TX_SYNC = 1;
    localparam int STK_RX_SYNC = 2;

    localparam logic [31:0] RESET_MASK = 32'h00000000;
    localparam logic [31:0] RESET_RDATA = 32'h00000000;

endpackage

//--- sticky_flag_bank.sv
`timescale 1ns/1ps
module sticky_flag_bank
    import serial_port_irq_mask_pkg::*;
#(
    parameter int WIDTH = 3
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [WIDTH-1:0] i_set,
    input wire logic [WIDTH-1:0] i_clear,
    output logic [WIDTH-1:0] o_flags
);

    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } bank_type;

    bank_type state_q;
    bank_type state_d;

    always_comb begin
        state_d = state_q;
        // Set wins so an event in the clearing cycle survives
        state_d.flags = (state_q.flags & ~i_clear) | i_set;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_flags = state_q.flags;

endmodule

//--- serial_port_irq_mask.sv
`timescale 1ns/1ps
// Contract
// - A write to the enable-set register sets each mask bit written as one and keeps the others.
// - A write to the enable-clear register clears each mask bit written as one and keeps the others.
// - Reading the mask view returns one for every enabled source and zero for every disabled one.
// - Transmit sources sit at bits 0 to 3: holding free, all sent, DMA count done, DMA buffers empty.
// - Receive sources sit at bits 4 to 7: holding full, overrun, DMA count done, DMA buffers full.
// - Transmit frame-sync sits at bit 10 and receive frame-sync at bit 11.
// - Both frame-sync flags set on their event and hold until the status word is next read, or written with a one at their bit.
// - Overrun sets when a receive word is loaded while the previous one is still unread.
module serial_port_irq_mask
    import serial_port_irq_mask_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DATA_W-1:0] o_rdata,
    input wire logic i_tx_holding_free,
    input wire logic i_tx_all_sent,
    input wire logic i_tx_dma_count_done,
    input wire logic i_tx_dma_buffers_empty,
    input wire logic i_rx_holding_full,
    input wire logic i_rx_dma_count_done,
    input wire logic i_rx_dma_buffers_full,
    input wire logic i_rx_word_load,
    input wire logic i_rx_holding_read,
    input wire logic i_tx_sync_event,
    input wire logic i_rx_sync_event,
    input wire logic i_tx_enabled,
    input wire logic i_rx_enabled,
    output logic o_irq
);

    typedef struct packed {
        logic [DATA_W-1:0] mask;
        logic [DATA_W-1:0] rdata;
        logic rx_unread;
        logic irq;
    } state_type;

    state_type state_q;
    state_type state_d;

    logic [STICKY_W-1:0] sticky_set;
    logic [STICKY_W-1:0] sticky_clear;
    logic [STICKY_W-1:0] sticky_q;
    logic [DATA_W-1:0] status_word;

    function automatic logic hit(
        input logic [ADDR_W-1:0] addr,
        input logic [7:0] ofs
    );
        hit = (addr == ofs[ADDR_W-1:0]);
    endfunction

    logic wr_set;
    logic wr_clear;
    logic wr_status;
    logic rd_status;
    logic overrun_hit;

    assign wr_set = i_wr && hit(i_addr, OFS_ENABLE_SET);
    assign wr_clear = i_wr && hit(i_addr, OFS_ENABLE_CLEAR);
    assign wr_status = i_wr && hit(i_addr, OFS_STATUS);
    assign rd_status = i_rd && hit(i_addr, OFS_STATUS);

    // A read in the same cycle as a load still counts as consumed
    assign overrun_hit = i_rx_word_load && state_q.rx_unread && !i_rx_holding_read;

    always_comb begin
        sticky_set = '0;
        sticky_set[STK_OVERRUN] = overrun_hit;
        sticky_set[STK_TX_SYNC] = i_tx_sync_event;
        sticky_set[STK_RX_SYNC] = i_rx_sync_event;
    end

    always_comb begin
        sticky_clear = '0;
        if (rd_status) begin
            sticky_clear = '1;
        end else if (wr_status) begin
            sticky_clear[STK_OVERRUN] = i_wdata[BIT_RX_OVERRUN_FLAG];
            sticky_clear[STK_TX_SYNC] = i_wdata[BIT_TX_FRAME_SYNC_SEEN];
            sticky_clear[STK_RX_SYNC] = i_wdata[BIT_RX_FRAME_SYNC_SEEN];
        end
    end

    sticky_flag_bank #(
        .WIDTH(STICKY_W)
    ) u_sticky (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_set(sticky_set),
        .i_clear(sticky_clear),
        .o_flags(sticky_q)
    );

    always_comb begin
        status_word = '0;
        status_word[BIT_TX_HOLDING_FREE] = i_tx_holding_free;
        status_word[BIT_TX_ALL_SENT] = i_tx_all_sent;
        status_word[BIT_TX_DMA_COUNT_DONE] = i_tx_dma_count_done;
        status_word[BIT_TX_DMA_BUFFERS_EMPTY] = i_tx_dma_buffers_empty;
        status_word[BIT_RX_HOLDING_FULL] = i_rx_holding_full;
        status_word[BIT_RX_OVERRUN_FLAG] = sticky_q[STK_OVERRUN];
        status_word[BIT_RX_DMA_COUNT_DONE] = i_rx_dma_count_done;
        status_word[BIT_RX_DMA_BUFFERS_FULL] = i_rx_dma_buffers_full;
        status_word[BIT_TX_FRAME_SYNC_SEEN] = sticky_q[STK_TX_SYNC];
        status_word[BIT_RX_FRAME_SYNC_SEEN] = sticky_q[STK_RX_SYNC];
        status_word[BIT_TX_ENABLED] = i_tx_enabled;
        status_word[BIT_RX_ENABLED] = i_rx_enabled;
    end

    always_comb begin
        state_d = state_q;

        // Reserved positions never reach the mask
        if (wr_set) begin
            state_d.mask = state_q.mask | (i_wdata & SOURCE_MASK);
        end else if (wr_clear) begin
            state_d.mask = state_q.mask & ~(i_wdata & SOURCE_MASK);
        end

        if (i_rx_word_load) begin
            state_d.rx_unread = 1'b1;
        end else if (i_rx_holding_read) begin
            state_d.rx_unread = 1'b0;
        end

        // Read data live only in the cycle after the strobe
        state_d.rdata = RESET_RDATA;
        if (i_rd) begin
            unique case (i_addr)
                OFS_STATUS[ADDR_W-1:0]: begin
                    state_d.rdata = status_word;
                end
                OFS_MASK_VIEW[ADDR_W-1:0]: begin
                    state_d.rdata = state_q.mask & SOURCE_MASK;
                end
                default: begin
                    state_d.rdata = RESET_RDATA;
                end
            endcase
        end

        // Registered to keep the line glitch free; one cycle behind
        state_d.irq = |(status_word & state_q.mask & SOURCE_MASK);
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_q.mask <= RESET_MASK;
            state_q.rdata <= RESET_RDATA;
            state_q.rx_unread <= 1'b0;
            state_q.irq <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_rdata = state_q.rdata;
    assign o_irq = state_q.irq;

    default clocking cb @(posedge i_clk);
    endclocking

    default disable iff (i_reset);

    sequence s_set_write;
        i_wr && i_addr == OFS_ENABLE_SET[ADDR_W-1:0];
    endsequence

    sequence s_clear_write;
        i_wr && i_addr == OFS_ENABLE_CLEAR[ADDR_W-1:0];
    endsequence

    sequence s_status_read;
        i_rd && i_addr == OFS_STATUS[ADDR_W-1:0];
    endsequence

    sequence s_mask_read;
        i_rd && i_addr == OFS_MASK_VIEW[ADDR_W-1:0];
    endsequence

    property p_enable_set;
        s_set_write |=>
            state_q.mask == ($past(state_q.mask) | ($past(i_wdata) & SOURCE_MASK));
    endproperty
    a_enable_set: assert property (p_enable_set)
        else $error("enable set write gave wrong mask");

    property p_enable_clear;
        s_clear_write |=>
            state_q.mask == ($past(state_q.mask) & ~($past(i_wdata) & SOURCE_MASK));
    endproperty
    a_enable_clear: assert property (p_enable_clear)
        else $error("enable clear write gave wrong mask");

    property p_mask_read;
        s_mask_read ##1 s_mask_read |=> o_rdata == $past(o_rdata)
            || $past(wr_set, 2) || $past(wr_clear, 2);
    endproperty
    a_mask_read_stable: assert property (p_mask_read)
        else $error("mask view changed without a mask write");

    property p_mask_after_set;
        s_set_write ##1 s_mask_read |=>
            (o_rdata & $past(i_wdata, 2) & SOURCE_MASK) == ($past(i_wdata, 2) & SOURCE_MASK);
    endproperty
    a_mask_after_set: assert property (p_mask_after_set)
        else $error("mask view misses an enabled source");

    property p_tx_bits;
        s_status_read |=> o_rdata[3:0] == {$past(i_tx_dma_buffers_empty),
            $past(i_tx_dma_count_done), $past(i_tx_all_sent), $past(i_tx_holding_free)};
    endproperty
    a_tx_bits: assert property (p_tx_bits)
        else $error("transmit status bits misplaced");

    property p_rx_bits;
        s_status_read |=> o_rdata[7:6] == {$past(i_rx_dma_buffers_full),
            $past(i_rx_dma_count_done)} && o_rdata[4] == $past(i_rx_holding_full);
    endproperty
    a_rx_bits: assert property (p_rx_bits)
        else $error("receive status bits misplaced");

    property p_sync_bits;
        i_tx_sync_event && i_rx_sync_event ##1 s_status_read |=>
            o_rdata[11:10] == 2'b11;
    endproperty
    a_sync_bits: assert property (p_sync_bits)
        else $error("frame sync bits misplaced");

    property p_sync_sticky;
        i_tx_sync_event ##1 (!rd_status && !wr_status)[*3] |->
            sticky_q[STK_TX_SYNC];
    endproperty
    a_sync_sticky: assert property (p_sync_sticky)
        else $error("transmit sync flag did not hold");

    property p_sync_read_clears;
        (s_status_read and !i_rx_sync_event) |=> !sticky_q[STK_RX_SYNC];
    endproperty
    a_sync_read_clears: assert property (p_sync_read_clears)
        else $error("status read left receive sync flag set");

    property p_overrun;
        i_rx_word_load && !i_rx_holding_read ##1 i_rx_word_load && !i_rx_holding_read
            |=> sticky_q[STK_OVERRUN];
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("second unread load did not flag overrun");

    property p_no_false_overrun;
        !sticky_q[STK_OVERRUN] && !state_q.rx_unread |=> !sticky_q[STK_OVERRUN];
    endproperty
    a_no_false_overrun: assert property (p_no_false_overrun)
        else $error("overrun without an unread word");

    property p_irq;
        |(status_word & state_q.mask) |=> o_irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt missing for enabled flag");

    property p_irq_quiet;
        state_q.mask == RESET_MASK |=> !o_irq;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("interrupt raised with all sources masked");

    property p_reserved;
        s_mask_read |=> (o_rdata & ~SOURCE_MASK) == '0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved mask bit reads nonzero");

    property p_rdata_idle;
        !i_rd |=> o_rdata == RESET_RDATA;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside a read");

    property p_unmapped_read;
        i_rd && i_addr != OFS_STATUS[ADDR_W-1:0] && i_addr != OFS_MASK_VIEW[ADDR_W-1:0] |=> o_rdata == RESET_RDATA;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read returned nonzero data");

    property p_mask_after_clear;
        s_clear_write ##1 s_mask_read |=> (o_rdata & $past(i_wdata, 2) & SOURCE_MASK) == '0;
    endproperty
    a_mask_after_clear: assert property (p_mask_after_clear)
        else $error("mask view shows a disabled source");

    property p_reserved_write;
        s_set_write |=> (state_q.mask & ~SOURCE_MASK) == '0;
    endproperty
    a_reserved_write: assert property (p_reserved_write)
        else $error("reserved bit entered the mask");

    property p_overrun_bit;
        s_status_read |=> o_rdata[BIT_RX_OVERRUN_FLAG] == $past(sticky_q[STK_OVERRUN]);
    endproperty
    a_overrun_bit: assert property (p_overrun_bit)
        else $error("overrun status bit misplaced");

    property p_sync_set_wins;
        rd_status && i_tx_sync_event |=> sticky_q[STK_TX_SYNC];
    endproperty
    a_sync_set_wins: assert property (p_sync_set_wins)
        else $error("sync event lost to a status read");

    property p_rx_sync_sticky;
        i_rx_sync_event ##1 (!rd_status && !wr_status)[*3] |-> sticky_q[STK_RX_SYNC];
    endproperty
    a_rx_sync_sticky: assert property (p_rx_sync_sticky)
        else $error("receive sync flag did not hold");

    property p_overrun_read_clears;
        rd_status && !i_rx_word_load |=> !sticky_q[STK_OVERRUN];
    endproperty
    a_overrun_read_clears: assert property (p_overrun_read_clears)
        else $error("status read left overrun set");

    property p_load_consumed;
        !sticky_q[STK_OVERRUN] && i_rx_word_load && i_rx_holding_read |=> !sticky_q[STK_OVERRUN];
    endproperty
    a_load_consumed: assert property (p_load_consumed)
        else $error("overrun on a load with a same-cycle read");

    property p_irq_low;
        (status_word & state_q.mask) == '0 |=> !o_irq;
    endproperty
    a_irq_low: assert property (p_irq_low)
        else $error("interrupt raised with no enabled flag");

endmodule

//--- serial_port_irq_mask_tb.sv
`timescale 1ns/1ps
module serial_port_irq_mask_tb;
    import serial_port_irq_mask_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [ADDR_W-1:0] i_addr = 8'h00;
    logic [DATA_W-1:0] i_wdata = 32'h00000000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [DATA_W-1:0] o_rdata;
    logic i_tx_holding_free = 1'b0, i_tx_all_sent = 1'b0, i_tx_dma_count_done = 1'b0;
    logic i_tx_dma_buffers_empty = 1'b0, i_rx_holding_full = 1'b0, i_rx_dma_count_done = 1'b0;
    logic i_rx_dma_buffers_full = 1'b0, i_rx_word_load = 1'b0, i_rx_holding_read = 1'b0;
    logic i_tx_sync_event = 1'b0, i_rx_sync_event = 1'b0, i_tx_enabled = 1'b0, i_rx_enabled = 1'b0;
    logic o_irq;
    int n_errors = 0;
    int compares = 0;
    logic [15:0] seed = 16'h16E6;
    logic [31:0] m_mask, m_st, exp_rdata;
    logic m_ovr, m_txs, m_rxs, m_unread, exp_irq;
    int rd_kind;
    logic [7:0] addr_tab [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'hFC, 8'h04, 8'h08};

    serial_port_irq_mask u_serial_port_irq_mask (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_tx_holding_free(i_tx_holding_free),
        .i_tx_all_sent(i_tx_all_sent), .i_tx_dma_count_done(i_tx_dma_count_done),
        .i_tx_dma_buffers_empty(i_tx_dma_buffers_empty), .i_rx_holding_full(i_rx_holding_full),
        .i_rx_dma_count_done(i_rx_dma_count_done), .i_rx_dma_buffers_full(i_rx_dma_buffers_full),
        .i_rx_word_load(i_rx_word_load), .i_rx_holding_read(i_rx_holding_read),
        .i_tx_sync_event(i_tx_sync_event), .i_rx_sync_event(i_rx_sync_event),
        .i_tx_enabled(i_tx_enabled), .i_rx_enabled(i_rx_enabled), .o_irq(o_irq));

    initial begin
        forever #12.5 i_clk = ~i_clk;
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Model of the status word as the design sees it at this edge
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            m_mask = 32'h00000000;
            {m_ovr, m_txs, m_rxs, m_unread, exp_irq} = 5'h00;
            exp_rdata = 32'h00000000;
            rd_kind = 0;
        end else begin
            m_st = {14'h0000, i_rx_enabled, i_tx_enabled, 4'h0, m_rxs, m_txs, 2'h0,
                    i_rx_dma_buffers_full, i_rx_dma_count_done, m_ovr, i_rx_holding_full,
                    i_tx_dma_buffers_empty, i_tx_dma_count_done, i_tx_all_sent, i_tx_holding_free};
            exp_irq = |(m_st & m_mask);
            exp_rdata = 32'h00000000;
            rd_kind = 0;
            if (i_rd) begin
                rd_kind = (i_addr == OFS_STATUS) ? 1 : (i_addr == OFS_MASK_VIEW) ? 2 : 3;
                exp_rdata = (rd_kind == 1) ? m_st : (rd_kind == 2) ? m_mask : 32'h00000000;
                if (rd_kind == 1) begin
                    {m_ovr, m_txs, m_rxs} = 3'h0;
                end
            end
            // Write-one on the status offset clears, before any set
            if (i_wr && i_addr == OFS_STATUS) begin
                m_ovr = m_ovr & ~i_wdata[BIT_RX_OVERRUN_FLAG];
                m_txs = m_txs & ~i_wdata[BIT_TX_FRAME_SYNC_SEEN];
                m_rxs = m_rxs & ~i_wdata[BIT_RX_FRAME_SYNC_SEEN];
            end
            if (i_wr && i_addr == OFS_ENABLE_SET) m_mask = m_mask | (i_wdata & SOURCE_MASK);
            if (i_wr && i_addr == OFS_ENABLE_CLEAR) m_mask = m_mask & ~(i_wdata & SOURCE_MASK);
            // Set wins over the clear by a status read
            if (i_tx_sync_event) m_txs = 1'b1;
            if (i_rx_sync_event) m_rxs = 1'b1;
            if (i_rx_word_load && m_unread && !i_rx_holding_read) m_ovr = 1'b1;
            if (i_rx_word_load) m_unread = 1'b1;
            else if (i_rx_holding_read) m_unread = 1'b0;
        end
    end

    task automatic chk_rdata(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t read data %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_irq(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t irq %b expected %b", $time, got, exp);
        end
    endtask

    // Falling edge: all updates of the rising edge have landed
    always @(negedge i_clk) begin
        chk_irq(o_irq, exp_irq);
        if (rd_kind == 1) chk_rdata(o_rdata, exp_rdata);
        else if (rd_kind == 2) chk_rdata(o_rdata, exp_rdata);
        else chk_rdata(o_rdata, exp_rdata);
    end

    task automatic bus_op(input logic wr, input logic rd, input logic [7:0] addr, input logic [31:0] data);
        @(posedge i_clk);
        i_wr <= wr;
        i_rd <= rd;
        i_addr <= addr;
        i_wdata <= data;
    endtask

    task automatic rand_cycle();
        logic [15:0] a, b;
        logic ld;
        seed = lfsr_next(seed);
        a = seed;
        seed = lfsr_next(seed);
        b = seed;
        // Status writes included: their write-one clear is modelled per bit
        if (a[1:0] == 2'h1) bus_op(1'b1, 1'b0, addr_tab[a[4:2]], {b, a});
        else if (a[1:0] == 2'h2) bus_op(1'b0, 1'b1, addr_tab[a[4:2]], {a, b});
        else bus_op(1'b0, 1'b0, addr_tab[a[4:2]], 32'h00000000);
        ld = (b[9:8] == 2'h0);
        {i_tx_holding_free, i_tx_all_sent, i_tx_dma_count_done, i_tx_dma_buffers_empty} <= a[8:5];
        {i_rx_holding_full, i_rx_dma_count_done, i_rx_dma_buffers_full} <= a[11:9];
        i_tx_sync_event <= (b[3:0] == 4'h0);
        i_rx_sync_event <= (b[7:4] == 4'h0);
        i_rx_word_load <= ld;
        // Load and holding read may share a cycle: the read counts as consumed
        i_rx_holding_read <= (b[11:10] == 2'h0);
        i_tx_enabled <= b[12];
        i_rx_enabled <= b[13];
    endtask

    task automatic tally_and_finish();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge i_clk);
        i_reset <= 1'b0;
        bus_op(1'b0, 1'b1, OFS_MASK_VIEW, 32'h00000000);
        bus_op(1'b1, 1'b0, OFS_ENABLE_SET, 32'hFFFFFFFF);
        bus_op(1'b1, 1'b0, OFS_MASK_VIEW, 32'h00000000);
        bus_op(1'b0, 1'b1, OFS_MASK_VIEW, 32'h00000000);
        bus_op(1'b1, 1'b0, OFS_ENABLE_CLEAR, 32'h00000555);
        bus_op(1'b0, 1'b1, OFS_MASK_VIEW, 32'h00000000);
        bus_op(1'b0, 1'b1, 8'hFC, 32'h00000000);
        repeat (1500) rand_cycle();
        bus_op(1'b0, 1'b0, 8'h00, 32'h00000000);
        i_reset <= 1'b1;
        @(posedge i_clk);
        i_reset <= 1'b0;
        repeat (1500) rand_cycle();
        bus_op(1'b0, 1'b0, 8'h00, 32'h00000000);
        repeat (3) @(posedge i_clk);
        tally_and_finish();
    end

    // Run needs about 3020 cycles
    initial begin
        repeat (6000) @(posedge i_clk);
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule
